// file: rgo_pkg.sv
package rgo_pkg;

  // ==========================================================
  // Datapath widths
  localparam int SAMPLE_W     = 10;
  localparam int MIX_W        = 12;
  localparam int CIC_W        = 96;
  localparam int WIN_W        = 11;
  localparam int PHASE_W      = 32;
  localparam int DIV_W        = 12;
  localparam int SER_W        = 16;

  // ==========================================================
  // Field positions and constants
  localparam int              MIX_DROP     = 7;
  localparam logic [20:0]     MIX_ROUND    = 21'h000040;
  localparam logic [6:0]      SHIFT_BIAS   = 7'h02;
  localparam logic [CIC_W-1:0] CIC_ROUND   = 96'h10_0000_0000;
  localparam int              WIN_LSB      = 37;
  localparam logic [21:0]     COMP_ROUND   = 22'h000080;
  localparam int              COMP_LSB     = 8;
  localparam logic [9:0]      COMP_BYPASS  = 10'h100;
  localparam logic [9:0]      COMP_FIRST   = 10'h0A6;
  localparam logic [9:0]      COMP_THIRD   = 10'h0C5;
  localparam int              PHASE_TOP    = 31;
  localparam int              PHASE_OUT_W  = 5;
  localparam logic [4:0]      SIM_BITS     = 5'h0A;
  localparam logic [4:0]      IQ_BITS      = 5'h10;
  localparam logic [5:0]      OFF_SER_LEN  = 6'h20;
  localparam logic [9:0]      OFFSET_FLIP  = 10'h200;
  localparam int              CLK_BIT      = 9;

  // ==========================================================
  // Compensation modes
  localparam logic [1:0] COMP_MODE_BYPASS = 2'h0;
  localparam logic [1:0] COMP_MODE_FIRST  = 2'h1;

  // ==========================================================
  // Serial formatter states
  typedef enum logic [2:0] {
    SER_IDLE  = 3'b001,
    SER_READY = 3'b010,
    SER_SHIFT = 3'b100
  } rgo_ser_t;

endpackage

// file: rgo_leg_if.sv
interface rgo_leg_if;
  import rgo_pkg::*;
  logic signed [SAMPLE_W-1:0] sample;
  logic signed [SAMPLE_W-1:0] lo;
  logic                       advance;
  logic                       dump;
  logic [3:0]                 agcMantissa;
  logic [5:0]                 shifterExp;
  logic                       thirdOrder;
  logic [1:0]                 compMode;
  logic signed [SAMPLE_W-1:0] result;
  logic                       resultValid;

  modport ctrl (output sample, lo, advance, dump, agcMantissa, shifterExp, thirdOrder,
                compMode, input result, resultValid);
  modport leg  (input sample, lo, advance, dump, agcMantissa, shifterExp, thirdOrder,
                compMode, output result, resultValid);
endinterface

// file: rgo_leg.sv
module rgo_leg
  import rgo_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Leg carrier
  rgo_leg_if.leg    lg
);

  logic signed [MIX_W-1:0] mix,      next_mix;
  logic signed [CIC_W-1:0] cicIn,    next_cicIn;
  logic signed [CIC_W-1:0] int1,     next_int1;
  logic signed [CIC_W-1:0] int2,     next_int2;
  logic signed [CIC_W-1:0] int3,     next_int3;
  logic signed [CIC_W-1:0] dly1,     next_dly1;
  logic signed [CIC_W-1:0] dly2,     next_dly2;
  logic signed [CIC_W-1:0] dly3,     next_dly3;
  logic signed [WIN_W-1:0] win,      next_win;
  logic signed [SAMPLE_W-1:0] res,   next_res;
  logic [1:0]              adv,      next_adv;
  logic [1:0]              dmp,      next_dmp;
  logic                    winValid, next_winValid;
  logic                    resValid, next_resValid;

  // ==========================================================
  // Mixer, gain chain, CIC, window and compensation
  always_comb
  begin
    logic signed [19:0]       prod;
    logic signed [20:0]       prodR;
    logic signed [17:0]       gained;
    logic [6:0]               shAmt;
    logic signed [CIC_W-1:0]  src;
    logic signed [CIC_W-1:0]  c1;
    logic signed [CIC_W-1:0]  c2;
    logic signed [CIC_W-1:0]  c3;
    logic signed [CIC_W-1:0]  rounded;
    logic signed [9:0]        coef;
    logic signed [21:0]       compR;
    rounded = '0;
    coef    = COMP_BYPASS;
    prod   = lg.sample * lg.lo;
    prodR  = 21'(prod) + MIX_ROUND;
    gained = mix * $signed({2'h0, 1'b1, lg.agcMantissa});
    shAmt  = {1'b0, lg.shifterExp} + SHIFT_BIAS;
    src    = lg.thirdOrder ? int3 : int1;
    c1     = src - dly1;
    c2     = c1 - dly2;
    c3     = c2 - dly3;
    next_mix = prodR[18:MIX_DROP];
    if (prodR[19] != prodR[18])
      next_mix = prodR[19] ? {1'b1, {(MIX_W-1){1'b0}}} : {1'b0, {(MIX_W-1){1'b1}}};
    // Fixed 2^-36 is folded into the CIC input LSB weight
    next_cicIn = CIC_W'(gained) <<< shAmt;
    next_adv   = {adv[0], lg.advance};
    next_dmp   = {dmp[0], lg.dump};
    next_int1  = int1;
    next_int2  = int2;
    next_int3  = int3;
    if (adv[1])
    begin
      next_int1 = int1 + cicIn;
      next_int2 = int2 + int1;
      next_int3 = int3 + int2;
    end
    next_dly1     = dly1;
    next_dly2     = dly2;
    next_dly3     = dly3;
    next_win      = win;
    next_winValid = dmp[1];
    if (dmp[1])
    begin
      next_dly1 = src;
      next_dly2 = c1;
      next_dly3 = c2;
      rounded   = (lg.thirdOrder ? c3 : c1) + CIC_ROUND;
      next_win  = rounded[WIN_LSB+WIN_W-1:WIN_LSB];
      if (rounded[CIC_W-1:WIN_LSB+WIN_W-1] != {(CIC_W-WIN_LSB-WIN_W+1){rounded[CIC_W-1]}})
        next_win = rounded[CIC_W-1] ? {1'b1, {(WIN_W-1){1'b0}}} : {1'b0, {(WIN_W-1){1'b1}}};
    end
    unique case (lg.compMode)
      COMP_MODE_BYPASS: coef = COMP_BYPASS;
      COMP_MODE_FIRST:  coef = COMP_FIRST;
      default:          coef = COMP_THIRD;
    endcase
    compR         = 22'(win * coef) + COMP_ROUND;
    next_res      = compR[COMP_LSB+SAMPLE_W-1:COMP_LSB];
    if (compR[21:COMP_LSB+SAMPLE_W-1] != {(22-COMP_LSB-SAMPLE_W+1){compR[21]}})
      next_res = compR[21] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
    next_resValid = winValid;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mix      <= '0;
      cicIn    <= '0;
      int1     <= '0;
      int2     <= '0;
      int3     <= '0;
      dly1     <= '0;
      dly2     <= '0;
      dly3     <= '0;
      win      <= '0;
      res      <= '0;
      adv      <= '0;
      dmp      <= '0;
      winValid <= 1'b0;
      resValid <= 1'b0;
    end
    else
    begin
      mix      <= next_mix;
      cicIn    <= next_cicIn;
      int1     <= next_int1;
      int2     <= next_int2;
      int3     <= next_int3;
      dly1     <= next_dly1;
      dly2     <= next_dly2;
      dly3     <= next_dly3;
      win      <= next_win;
      res      <= next_res;
      adv      <= next_adv;
      dmp      <= next_dmp;
      winValid <= next_winValid;
      resValid <= next_resValid;
    end
  end

  assign lg.result      = res;
  assign lg.resultValid = resValid;

endmodule

// file: rgo_resampler_formatter.sv
// Summary of operation
// - Phase accumulator adds center plus offset word per sample, carry on wrap.
// - Center word comes from a port; offset word loads through serial pins.
// - Gated mode steps per input enable; interpolated mode steps every clock.
// - In adjustable rate mode carry-outs enable the output-rate divider.
// - Carry drives the sample strobe; phaseWindowSel picks which five phase bits drive phase outputs.
// - Formatter offers parallel or serial, two's complement or offset binary.
// - Parallel mode shows I and Q together and flags the first valid cycle.
// - Separate active-low enables release the I bus and the Q bus.
// - Data-ready polarity is selectable.
// - Simultaneous serial mode sends I on I bit 0 and Q on Q bit 0.
// - I-then-Q mode sends 16-bit words, data in the ten upper bits.
// - Word LSB tags I against Q; here the I word carries the 1.
// - Serial clock on I bit 9 is main clock divided by 2, 4 or 8.
// - With factor 1, I bit 9 stays high; receiver uses main clock.
// - Data-ready leads each serial word by one serial clock period.
// - Serial bit order is MSB first or LSB first.
// - Mixer multiplies 10-bit input by 10-bit sinusoid, rounds to 12 bits.
// - Both legs scaled by fixed gain of two to the minus thirty-six.
// - Adaptive gain 1.0 to 1.9375 times 2^6; shifter 2^0 to 2^63.
// - CIC gain is decimation to the order, order 1 or 3, up to 4096.
// - CIC output rounded into an 11-bit window, saturating on overflow.
// - Compensation gain 1.0, 0.65 or 0.77, output rounded and limited to 10 bits.
// - Output divider decrements per enable, samples at terminal count, 1 to 4096.
module rgo_resampler_formatter
  import rgo_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Sample inputs
  input  wire logic signed [SAMPLE_W-1:0] inphaseIn,
  input  wire logic signed [SAMPLE_W-1:0] quadratureIn,
  input  wire logic signed [SAMPLE_W-1:0] loCos,
  input  wire logic signed [SAMPLE_W-1:0] loSin,
  input  wire logic                       inputSampleEnableN,
  input  wire logic                       gatedInputMode,
  // Re-sampler control
  input  wire logic [PHASE_W-1:0]         samplerCenterFreqWord,
  input  wire logic                       offsetSerialData,
  input  wire logic                       offsetWordSync,
  input  wire logic                       adjustableRate,
  input  wire logic [DIV_W:0]             rateDivisor,
  input  wire logic [1:0]                 phaseWindowSel,
  // Gain control
  input  wire logic [3:0]                 agcMantissa,
  input  wire logic [5:0]                 shifterExp,
  input  wire logic                       cicThirdOrder,
  input  wire logic [1:0]                 compMode,
  // Formatter control
  input  wire logic                       serialMode,
  input  wire logic                       iThenQMode,
  input  wire logic                       offsetBinary,
  input  wire logic                       validActiveLow,
  input  wire logic                       lsbFirst,
  input  wire logic [1:0]                 serialClockFactor,
  input  wire logic                       inphaseBusEnableN,
  input  wire logic                       quadratureBusEnableN,
  // Re-sampler outputs
  output logic                            sampleStrobeOut,
  output logic [PHASE_OUT_W-1:0]          resamplerPhaseOut,
  // Data outputs
  output logic [SAMPLE_W-1:0]             inphaseOutBus,
  output logic                            inphaseOutOe,
  output logic [SAMPLE_W-1:0]             quadratureOutBus,
  output logic                            quadratureOutOe,
  output logic                            outputWordValid
);

  // ==========================================================
  // Pin synchronisers
  logic [4:0] syncA, next_syncA;
  logic [4:0] syncB, next_syncB;
  logic       enSample, offData, offSync, oeIN, oeQN;

  always_comb
  begin
    next_syncA = {quadratureBusEnableN, inphaseBusEnableN, offsetWordSync, offsetSerialData,
                  inputSampleEnableN};
    next_syncB = syncA;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      syncA <= 5'h1F;
      syncB <= 5'h1F;
    end
    else
    begin
      syncA <= next_syncA;
      syncB <= next_syncB;
    end
  end

  assign enSample = ~syncB[0];
  assign offData  = syncB[1];
  assign offSync  = syncB[2];
  assign oeIN     = syncB[3];
  assign oeQN     = syncB[4];

  // ==========================================================
  // Re-sampler NCO, offset loader and output-rate divider
  logic [PHASE_W-1:0] phase,     next_phase;
  logic [PHASE_W-1:0] offWord,   next_offWord;
  logic [PHASE_W-1:0] offShift,  next_offShift;
  logic [5:0]         offCnt,    next_offCnt;
  logic [DIV_W-1:0]   divCnt,    next_divCnt;
  logic               strobe,    next_strobe;
  logic [PHASE_OUT_W-1:0] phOut, next_phOut;
  logic               advance;
  logic               dump;

  always_comb
  begin
    logic [PHASE_W:0] sum;
    logic             carry;
    logic             divEn;
    advance      = gatedInputMode ? enSample : 1'b1;
    sum          = {1'b0, phase} + {1'b0, samplerCenterFreqWord} + {1'b0, offWord};
    carry        = advance & sum[PHASE_W];
    next_phase   = advance ? sum[PHASE_W-1:0] : phase;
    next_strobe  = carry;
    next_phOut   = phase[PHASE_TOP - phaseWindowSel -: PHASE_OUT_W];
    // Offset word arrives MSB first after a one-cycle sync pulse
    next_offShift = offShift;
    next_offCnt   = offCnt;
    next_offWord  = offWord;
    if (offSync)
      next_offCnt = OFF_SER_LEN;
    else if (offCnt != 6'h00)
    begin
      next_offShift = {offShift[PHASE_W-2:0], offData};
      next_offCnt   = offCnt - 6'h01;
      if (offCnt == 6'h01)
        next_offWord = {offShift[PHASE_W-2:0], offData};
    end
    divEn       = adjustableRate ? carry : advance;
    dump        = divEn && (divCnt == '0);
    next_divCnt = divCnt;
    if (divEn)
      next_divCnt = dump ? DIV_W'(rateDivisor - 13'h0001) : divCnt - 12'h001;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase    <= '0;
      offWord  <= '0;
      offShift <= '0;
      offCnt   <= '0;
      divCnt   <= '0;
      strobe   <= 1'b0;
      phOut    <= '0;
    end
    else
    begin
      phase    <= next_phase;
      offWord  <= next_offWord;
      offShift <= next_offShift;
      offCnt   <= next_offCnt;
      divCnt   <= next_divCnt;
      strobe   <= next_strobe;
      phOut    <= next_phOut;
    end
  end

  assign sampleStrobeOut   = strobe;
  assign resamplerPhaseOut = phOut;

  // ==========================================================
  // Gain and filter legs
  rgo_leg_if legI ();
  rgo_leg_if legQ ();

  assign legI.sample      = inphaseIn;
  assign legI.lo          = loCos;
  assign legQ.sample      = quadratureIn;
  assign legQ.lo          = loSin;
  assign legI.advance     = advance;
  assign legQ.advance     = advance;
  assign legI.dump        = dump;
  assign legQ.dump        = dump;
  assign legI.agcMantissa = agcMantissa;
  assign legQ.agcMantissa = agcMantissa;
  assign legI.shifterExp  = shifterExp;
  assign legQ.shifterExp  = shifterExp;
  assign legI.thirdOrder  = cicThirdOrder;
  assign legQ.thirdOrder  = cicThirdOrder;
  assign legI.compMode    = compMode;
  assign legQ.compMode    = compMode;

  rgo_leg legInst_i (
    .clk    (clk),
    .resetn (resetn),
    .lg     (legI.leg)
  );

  rgo_leg legInst_q (
    .clk    (clk),
    .resetn (resetn),
    .lg     (legQ.leg)
  );

  // ==========================================================
  // Output formatter
  rgo_ser_t          serState, next_serState;
  logic [SER_W-1:0]  shI,      next_shI;
  logic [SER_W-1:0]  shQ,      next_shQ;
  logic [SER_W-1:0]  heldQ,    next_heldQ;
  logic [4:0]        bitCnt,   next_bitCnt;
  logic [2:0]        tickCnt,  next_tickCnt;
  logic              secondWord, next_secondWord;
  logic              sclk,     next_sclk;
  logic              valid,    next_valid;
  logic [SAMPLE_W-1:0] iBus,   next_iBus;
  logic [SAMPLE_W-1:0] qBus,   next_qBus;
  logic              inphase_bus_enable_n,      next_oeI;
  logic              quadrature_bus_enable_n,      next_oeQ;

  always_comb
  begin
    logic [SAMPLE_W-1:0] iS;
    logic [SAMPLE_W-1:0] qS;
    logic [2:0]          lastTick;
    logic                tick;
    logic [4:0]          wordLen;
    logic                bitI;
    logic                bitQ;
    iS       = offsetBinary ? legI.result ^ OFFSET_FLIP : legI.result;
    qS       = offsetBinary ? legQ.result ^ OFFSET_FLIP : legQ.result;
    lastTick = 3'((4'h1 << serialClockFactor) - 4'h1);
    tick     = (tickCnt == lastTick);
    wordLen  = iThenQMode ? IQ_BITS : SIM_BITS;
    bitI     = lsbFirst ? shI[0] : shI[SER_W-1];
    bitQ     = lsbFirst ? shQ[0] : shQ[SER_W-1];
    next_tickCnt    = tick ? 3'h0 : tickCnt + 3'h1;
    // Low half then high half, so data settles before the rising edge
    next_sclk       = (serialClockFactor == 2'h0) ? 1'b1
                      : (next_tickCnt > (lastTick >> 1));
    next_serState   = serState;
    next_shI        = shI;
    next_shQ        = shQ;
    next_heldQ      = heldQ;
    next_bitCnt     = bitCnt;
    next_secondWord = secondWord;
    next_valid      = 1'b0;
    next_iBus       = iBus;
    next_qBus       = qBus;
    next_oeI        = ~oeIN;
    next_oeQ        = ~oeQN;
    if (!serialMode)
    begin
      next_serState = SER_IDLE;
      if (legI.resultValid)
      begin
        next_iBus  = iS;
        next_qBus  = qS;
        next_valid = 1'b1;
      end
    end
    else
    begin
      next_iBus[CLK_BIT] = next_sclk;
      unique case (serState)
        SER_IDLE:
          if (legI.resultValid)
          begin
            // Samples landing while a word is still shifting are dropped
            if (iThenQMode)
            begin
              next_shI   = {iS, 5'h00, 1'b1};
              next_heldQ = {qS, 5'h00, 1'b0};
            end
            else
            begin
              next_shI = lsbFirst ? {6'h00, iS} : {iS, 6'h00};
              next_shQ = lsbFirst ? {6'h00, qS} : {qS, 6'h00};
            end
            next_secondWord = 1'b0;
            next_serState   = SER_READY;
          end
        SER_READY:
        begin
          next_valid = valid;
          if (tick)
          begin
            next_valid    = 1'b1;
            next_bitCnt   = wordLen;
            next_serState = SER_SHIFT;
          end
        end
        SER_SHIFT:
        begin
          next_valid = valid;
          if (tick)
          begin
            next_valid = 1'b0;
            if (bitCnt != 5'h00)
            begin
              next_iBus[0] = bitI;
              next_qBus[0] = iThenQMode ? 1'b0 : bitQ;
              next_shI     = lsbFirst ? shI >> 1 : shI << 1;
              next_shQ     = lsbFirst ? shQ >> 1 : shQ << 1;
              next_bitCnt  = bitCnt - 5'h01;
            end
            else if (iThenQMode && !secondWord)
            begin
              next_shI        = heldQ;
              next_secondWord = 1'b1;
              next_valid      = 1'b1;
              next_bitCnt     = wordLen;
            end
            else
              next_serState = SER_IDLE;
          end
        end
        default:
          next_serState = SER_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      serState   <= SER_IDLE;
      shI        <= '0;
      shQ        <= '0;
      heldQ      <= '0;
      bitCnt     <= '0;
      tickCnt    <= '0;
      secondWord <= 1'b0;
      sclk       <= 1'b1;
      valid      <= 1'b0;
      iBus       <= '0;
      qBus       <= '0;
      inphase_bus_enable_n        <= 1'b0;
      quadrature_bus_enable_n        <= 1'b0;
      outputWordValid <= 1'b0;
    end
    else
    begin
      serState   <= next_serState;
      shI        <= next_shI;
      shQ        <= next_shQ;
      heldQ      <= next_heldQ;
      bitCnt     <= next_bitCnt;
      tickCnt    <= next_tickCnt;
      secondWord <= next_secondWord;
      sclk       <= next_sclk;
      valid      <= next_valid;
      iBus       <= next_iBus;
      qBus       <= next_qBus;
      inphase_bus_enable_n        <= next_oeI;
      quadrature_bus_enable_n        <= next_oeQ;
      outputWordValid <= next_valid ^ validActiveLow;
    end
  end

  assign inphaseOutBus    = iBus;
  assign inphaseOutOe     = inphase_bus_enable_n;
  assign quadratureOutBus = qBus;
  assign quadratureOutOe  = quadrature_bus_enable_n;

endmodule

// file: rgo_asserts.sv
module rgo_asserts
  import rgo_pkg::*;
(
  // Clock, reset and controls
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic                   inputSampleEnableN,
  input wire logic                   gatedInputMode,
  input wire logic [DIV_W:0]         rateDivisor,
  input wire logic                   serialMode,
  input wire logic                   validActiveLow,
  input wire logic [1:0]             serialClockFactor,
  input wire logic                   inphaseBusEnableN,
  input wire logic                   quadratureBusEnableN,
  // Outputs
  input wire logic                   sampleStrobeOut,
  input wire logic [PHASE_OUT_W-1:0] resamplerPhaseOut,
  input wire logic [SAMPLE_W-1:0]    inphaseOutBus,
  input wire logic                   inphaseOutOe,
  input wire logic                   quadratureOutOe,
  input wire logic                   outputWordValid
);
  // ==========
  // Port relations
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic polPrev;
  // Polarity that the registered flag was launched with
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      polPrev <= 1'b0;
    else
      polPrev <= validActiveLow;
  end
  wire act  = outputWordValid ^ polPrev;
  wire sclk = inphaseOutBus[CLK_BIT];
  sequence s_turn;
    $stable(sclk) ##1 !$stable(sclk);
  endsequence
  a_oe_i_drive: assert property (!inphaseBusEnableN [*5] |-> inphaseOutOe)
    else $error("I bus not driven");
  a_oe_q_release: assert property (quadratureBusEnableN [*5] |-> !quadratureOutOe)
    else $error("Q bus not released");
  a_sclk_held: assert property ((serialMode && serialClockFactor == 2'h0) [*6] |-> sclk)
    else $error("serial clock not high");
  a_sclk_half: assert property ((serialMode && serialClockFactor == 2'h1) [*6] |-> !$stable(sclk))
    else $error("serial clock not halved");
  a_sclk_quarter: assert property ((serialMode && serialClockFactor == 2'h2) [*8] ##0 !$stable(sclk)
    |=> s_turn) else $error("serial clock not quartered");
  a_valid_pulse: assert property (!serialMode && rateDivisor > 13'h1 && act |=> !act)
    else $error("valid longer than one cycle");
  a_bus_hold: assert property (!serialMode [*3] ##0 !act |-> $stable(inphaseOutBus))
    else $error("bus moved without valid");
  a_gated_idle: assert property ((gatedInputMode && inputSampleEnableN) [*6]
    |-> $stable(resamplerPhaseOut) && !sampleStrobeOut) else $error("phase moved while idle");
endmodule
bind rgo_resampler_formatter rgo_asserts i_rgo_asserts (.*);

// file: rgo_dsp_rx.sv
module rgo_dsp_rx
  import rgo_pkg::*;
(
  // Clock and formatter side
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic [SAMPLE_W-1:0] iBus,
  input  wire logic [SAMPLE_W-1:0] qBus,
  input  wire logic                wordValid,
  input  wire logic                activeLow,
  // Captured words
  output logic [SAMPLE_W-1:0]      lastI,
  output logic [SAMPLE_W-1:0]      lastQ,
  output int                       words
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Parallel capture
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      words <= 0;
    else if (wordValid ^ activeLow)
    begin
      lastI <= iBus;
      lastQ <= qBus;
      words <= words + 1;
    end
endmodule

// file: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rgo_pkg::*;
  // ==========
  // Bench
  logic clk, resetn, inputSampleEnableN, gatedInputMode, offsetSerialData, offsetWordSync;
  logic adjustableRate, serialMode, iThenQMode, offsetBinary, validActiveLow, lsbFirst;
  logic inphaseBusEnableN, quadratureBusEnableN, sampleStrobeOut, inphaseOutOe;
  logic quadratureOutOe, outputWordValid, cicThirdOrder;
  logic signed [SAMPLE_W-1:0] inphaseIn, quadratureIn, loCos, loSin;
  logic [SAMPLE_W-1:0] inphaseOutBus, quadratureOutBus, lastI, lastQ;
  logic [PHASE_W-1:0] samplerCenterFreqWord;
  logic [DIV_W:0] rateDivisor;
  logic [1:0] phaseWindowSel, compMode, serialClockFactor;
  logic [3:0] agcMantissa;
  logic [5:0] shifterExp;
  logic [PHASE_OUT_W-1:0] resamplerPhaseOut;
  logic [15:0] wi, wq;
  int words, nStrobe, s, miscompares, cmp_count;
  rgo_resampler_formatter i_rgo_resampler_formatter (.*);
  rgo_dsp_rx i_rgo_dsp_rx (.clk, .resetn, .iBus(inphaseOutBus), .qBus(quadratureOutBus),
    .wordValid(outputWordValid), .activeLow(validActiveLow), .lastI, .lastQ, .words);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk)
    if (sampleStrobeOut === 1'b1)
      nStrobe++;
  task tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, g);
      miscompares++;
    end
  endtask
  // Waits for the word flag, then shifts in len bits from both data lines
  task get(int len);
    repeat (400)
    begin
      @(posedge clk);
      #1;
      if ((outputWordValid ^ validActiveLow) === 1'b1)
        break;
    end
    repeat (len)
    begin
      @(posedge clk);
      #1;
      wi = {wi[14:0], inphaseOutBus[0]};
      wq = {wq[14:0], quadratureOutBus[0]};
    end
  endtask
  task get_i(int p);
    for (int k = 0; k < 4; k++)
    begin
      get(16);
      if (wi[p] === 1'b1)
        break;
    end
  endtask
  task t_gated;
    samplerCenterFreqWord <= 32'h8000_0000;
    gatedInputMode <= 1'b1;
    tick(10);
    s = nStrobe;
    repeat (7)
    begin
      inputSampleEnableN <= 1'b0;
      tick(1);
      inputSampleEnableN <= 1'b1;
      tick(3);
    end
    tick(12);
    chk("gated", 16'h0003, 16'(nStrobe - s));
    chk("phase", 16'h0010, {11'h000, resamplerPhaseOut});
    gatedInputMode <= 1'b0;
  endtask
  task t_nco;
    samplerCenterFreqWord <= 32'h4000_0000;
    tick(8);
    s = nStrobe;
    tick(64);
    chk("center", 16'h0010, 16'(nStrobe - s));
    offsetWordSync <= 1'b1;
    tick(1);
    offsetWordSync <= 1'b0;
    for (int b = 31; b >= 0; b--)
    begin
      offsetSerialData <= (b == 30);
      tick(1);
    end
    offsetSerialData <= 1'b0;
    tick(8);
    s = nStrobe;
    tick(64);
    chk("summed", 16'h0020, 16'(nStrobe - s));
  endtask
  task t_rate;
    adjustableRate <= 1'b1;
    tick(20);
    s = words;
    tick(64);
    chk("carry rate", 16'h0010, 16'(words - s));
    adjustableRate <= 1'b0;
    tick(20);
    s = words;
    tick(64);
    chk("fixed rate", 16'h0020, 16'(words - s));
  endtask
  task t_par;
    chk("I sat", 16'h01FF, {6'h00, lastI});
    chk("Q sat", 16'h0200, {6'h00, lastQ});
    offsetBinary <= 1'b1;
    validActiveLow <= 1'b1;
    inphaseBusEnableN <= 1'b1;
    quadratureBusEnableN <= 1'b0;
    inphaseIn <= 10'h000;
    loCos <= 10'h155;
    quadratureIn <= 10'h200;
    tick(40);
    chk("I offset", 16'h0200, {6'h00, lastI});
    chk("Q offset", 16'h03FF, {6'h00, lastQ});
    chk("oe", 16'h0001, {14'h0000, inphaseOutOe, quadratureOutOe});
  endtask
  task t_ser;
    offsetBinary <= 1'b0;
    validActiveLow <= 1'b0;
    inphaseIn <= 10'h1FF;
    loCos <= 10'h1FF;
    serialMode <= 1'b1;
    iThenQMode <= 1'b1;
    tick(30);
    get_i(0);
    chk("I word", 16'h7FC1, wi);
    get(16);
    chk("Q word", 16'h7FC0, wi);
    tick(1);
    lsbFirst <= 1'b1;
    tick(40);
    get_i(15);
    chk("I reversed", 16'h83FE, wi);
    tick(1);
    iThenQMode <= 1'b0;
    lsbFirst <= 1'b0;
    tick(40);
    get(10);
    chk("sim I", 16'h01FF, wi & 16'h03FF);
    chk("sim Q", 16'h01FF, wq & 16'h03FF);
    tick(1);
    for (int f = 1; f < 4; f++)
    begin
      serialClockFactor <= 2'(f);
      tick(30);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    tick(20000);
    miscompares++;
    test_done();
  end
  initial
  begin
    {resetn, gatedInputMode, offsetSerialData, offsetWordSync, adjustableRate} = 5'h00;
    {serialMode, iThenQMode, offsetBinary, validActiveLow, lsbFirst} = 5'h00;
    {inputSampleEnableN, inphaseBusEnableN, quadratureBusEnableN} = 3'h5;
    {cicThirdOrder, compMode, phaseWindowSel, serialClockFactor} = 7'h40;
    agcMantissa = 4'hF;
    shifterExp = 6'h3F;
    rateDivisor = 13'h0002;
    samplerCenterFreqWord = 32'h0000_0000;
    {inphaseIn, quadratureIn, loCos, loSin} = {10'h1FF, 10'h1FF, 10'h1FF, 10'h200};
    wi = 16'h0000;
    wq = 16'h0000;
    tick(12);
    resetn <= 1'b1;
    t_gated();
    t_nco();
    t_rate();
    t_par();
    t_ser();
    test_done();
  end
endmodule
